// ==== logic/slpd_pkg.sv ====
package slpd_pkg;

  // ---------------------------------------------------------------
  // Clock and timebase
  // ---------------------------------------------------------------
  localparam int SLPD_CLK_HZ = 10_000_000;
  localparam int SLPD_MS_PER_S = 1000;
  localparam int SLPD_MS_CYCLES = SLPD_CLK_HZ / SLPD_MS_PER_S;

  // ---------------------------------------------------------------
  // Pattern timing, in milliseconds
  // ---------------------------------------------------------------
  localparam int SLPD_MSCNT_W = 10;
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_BLINK_HALF_MS = 10'h0c8;
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_FLASH_ON_MS = 10'h0c8;
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_FLASH_GAP_MS = 10'h0c8;
  localparam int SLPD_DARK_S = 1;
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_DARK_MS = SLPD_MSCNT_W'(SLPD_DARK_S * SLPD_MS_PER_S);
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_FLICKER_PERIOD_MS = 10'h032;
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_FLICKER_HALF_MS = SLPD_FLICKER_PERIOD_MS >> 1;
  // Short activity pulses are stretched so the flicker is visible at all.
  localparam logic [SLPD_MSCNT_W-1:0] SLPD_ACT_HOLD_MS = 10'h064;

  localparam logic [1:0] SLPD_FLASHES_SINGLE = 2'h1;
  localparam logic [1:0] SLPD_FLASHES_DOUBLE = 2'h2;
  localparam logic [1:0] SLPD_FLASHES_TRIPLE = 2'h3;

  typedef enum logic [2:0] {
    SLPD_PAT_OFF,
    SLPD_PAT_ON,
    SLPD_PAT_BLINK,
    SLPD_PAT_SINGLE,
    SLPD_PAT_DOUBLE,
    SLPD_PAT_TRIPLE,
    SLPD_PAT_FLICKER
  } slpd_pat_t;

  // ---------------------------------------------------------------
  // LEDs and module state
  // ---------------------------------------------------------------
  localparam int SLPD_PORTS = 2;
  localparam int SLPD_GREEN_N = 3;
  localparam int SLPD_LED_PWR = 0;
  localparam int SLPD_LED_LINK0 = 1;

  typedef struct packed {
    logic motor_comm;
    logic module_pwr;
    logic bus_fail;
    logic sys_fail;
    logic [SLPD_PORTS-1:0] line_act;
    logic [SLPD_PORTS-1:0] link_up;
  } slpd_in_t;

  typedef struct packed {
    logic bus_led;
    logic sys_led;
    logic [SLPD_GREEN_N-1:0] green;
    slpd_in_t live;
  } slpd_stat_t;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam int SLPD_ADDR_W = 5;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_STATUS = 5'h00;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_CTRL = 5'h04;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_OVR_PAT = 5'h08;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_IRQ_STATUS = 5'h0c;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_IRQ_CLEAR = 5'h10;
  localparam logic [SLPD_ADDR_W-1:0] SLPD_REG_IRQ_ENABLE = 5'h14;

  localparam int SLPD_IRQ_N = 5;
  localparam int SLPD_EV_SYS_FAIL = 0;
  localparam int SLPD_EV_BUS_FAIL = 1;
  localparam int SLPD_EV_LINK0 = 2;
  localparam int SLPD_EV_COMM_LOSS = 4;

endpackage

// ==== logic/slpd_pattern.sv ====
`timescale 1ns/100ps
module slpd_pattern
  import slpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ms_tick,
  input wire slpd_pat_t i_pattern,
  output logic o_led
);

  typedef struct packed {
    slpd_pat_t pat;
    logic [SLPD_MSCNT_W-1:0] cnt;
    logic [1:0] idx;
    logic on;
    logic led;
  } slpd_gen_st_t;

  slpd_gen_st_t st_reg;
  slpd_gen_st_t st_next;
  logic [1:0] flashes;
  logic flash;
  logic last;
  logic [SLPD_MSCNT_W-1:0] lim;

  always_comb
  begin
    st_next = st_reg;
    flash = 1'b1;
    case (st_reg.pat)
      SLPD_PAT_SINGLE: flashes = SLPD_FLASHES_SINGLE;
      SLPD_PAT_DOUBLE: flashes = SLPD_FLASHES_DOUBLE;
      SLPD_PAT_TRIPLE: flashes = SLPD_FLASHES_TRIPLE;
      default:
      begin
        flashes = SLPD_FLASHES_SINGLE;
        flash = 1'b0;
      end
    endcase
    last = flash && (st_reg.idx == flashes - 2'h1);
    if (st_reg.pat == SLPD_PAT_FLICKER)
      lim = SLPD_FLICKER_HALF_MS;
    else if (st_reg.on)
      lim = flash ? SLPD_FLASH_ON_MS : SLPD_BLINK_HALF_MS;
    else if (last)
      lim = SLPD_DARK_MS;
    else
      lim = flash ? SLPD_FLASH_GAP_MS : SLPD_BLINK_HALF_MS;
    if (i_pattern != st_reg.pat)
    begin
      // A new pattern always starts at the head of its on phase.
      st_next.pat = i_pattern;
      st_next.cnt = '0;
      st_next.idx = '0;
      st_next.on = 1'b1;
    end
    else if (i_ms_tick)
    begin
      if (st_reg.cnt == lim - 1'b1)
      begin
        st_next.cnt = '0;
        st_next.on = !st_reg.on;
        if (!st_reg.on)
          st_next.idx = last ? 2'h0 : st_reg.idx + 2'h1;
      end
      else
        st_next.cnt = st_reg.cnt + 1'b1;
    end
    st_next.led = (st_next.pat == SLPD_PAT_ON) || ((st_next.pat != SLPD_PAT_OFF) && st_next.on);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_reg.pat <= SLPD_PAT_OFF;
      st_reg.cnt <= '0;
      st_reg.idx <= '0;
      st_reg.on <= 1'b0;
      st_reg.led <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  assign o_led = st_reg.led;

endmodule

// ==== logic/slpd_top.sv ====
// Behaviour
// - Blink is 200 ms on, 200 ms off.
// - Single flash: 200 ms on, 1 s dark.
// - Double flash: two 200 ms flashes, 1 s dark.
// - Triple flash: three 200 ms flashes, 1 s dark.
// - Flicker toggles with a 50 ms period.
// - Link LED off, on, flicker with traffic.
// - Red LEDs steady, follow their failure inputs.
// - Power LED on, flicker without motor, off.
`timescale 1ns/100ps
module slpd_top
  import slpd_pkg::*;
#(
  parameter int MS_CYCLES = SLPD_MS_CYCLES
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [SLPD_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [SLPD_PORTS-1:0] I_LINK_UP,
  input wire logic [SLPD_PORTS-1:0] I_LINE_ACT,
  input wire logic I_SYSTEM_FAIL,
  input wire logic I_BUS_FAIL,
  input wire logic I_MODULE_PWR,
  input wire logic I_MOTOR_COMM,
  output logic O_POWER_COMM_LED,
  output logic [SLPD_PORTS-1:0] O_LINK_ACT_LED,
  output logic O_SYSTEM_FAILURE_LED,
  output logic O_BUS_FAILURE_LED,
  output logic O_IRQ
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam int MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

  typedef struct packed {
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    slpd_in_t prev;
    logic [SLPD_PORTS-1:0][SLPD_MSCNT_W-1:0] act_cnt;
    slpd_pat_t [SLPD_GREEN_N-1:0] pat_sel;
    logic sys_led;
    logic bus_led;
    logic [SLPD_GREEN_N-1:0] ovr_en;
    slpd_pat_t ovr_pat;
    logic [SLPD_IRQ_N-1:0] irq_stat;
    logic [SLPD_IRQ_N-1:0] irq_en;
    logic irq;
    logic wait_req;
    logic [31:0] rdata;
  } slpd_top_st_t;

  slpd_top_st_t st_reg;
  slpd_top_st_t st_next;
  slpd_in_t live;
  slpd_stat_t stat;
  logic [SLPD_GREEN_N-1:0] green;
  logic [SLPD_IRQ_N-1:0] ev;
  logic [SLPD_IRQ_N-1:0] clr;
  logic [SLPD_PORTS-1:0] active;
  logic [SLPD_ADDR_W-1:0] addr;
  logic wr_go;

  assign live = '{motor_comm: I_MOTOR_COMM, module_pwr: I_MODULE_PWR, bus_fail: I_BUS_FAIL,
                  sys_fail: I_SYSTEM_FAIL, line_act: I_LINE_ACT, link_up: I_LINK_UP};
  assign stat = '{bus_led: st_reg.bus_led, sys_led: st_reg.sys_led, green: green, live: st_reg.prev};
  assign addr = {I_AVS_ADDRESS[SLPD_ADDR_W-1:2], 2'h0};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.prev = live;

    // Millisecond timebase shared by every pattern generator.
    if (st_reg.ms_cnt == MS_LAST)
    begin
      st_next.ms_cnt = '0;
      st_next.ms_tick = 1'b1;
    end
    else
    begin
      st_next.ms_cnt = st_reg.ms_cnt + 1'b1;
      st_next.ms_tick = 1'b0;
    end

    // Traffic pulses may be one cycle wide, so each is held for a while.
    for (int i = 0; i < SLPD_PORTS; i++)
    begin
      if (live.line_act[i])
        st_next.act_cnt[i] = SLPD_ACT_HOLD_MS;
      else if (st_reg.ms_tick && (st_reg.act_cnt[i] != '0))
        st_next.act_cnt[i] = st_reg.act_cnt[i] - 1'b1;
      active[i] = live.line_act[i] || (st_reg.act_cnt[i] != '0);
    end

    // Pattern choice for the green LEDs.
    for (int i = 0; i < SLPD_PORTS; i++)
    begin
      if (!live.link_up[i])
        st_next.pat_sel[SLPD_LED_LINK0 + i] = SLPD_PAT_OFF;
      else if (active[i])
        st_next.pat_sel[SLPD_LED_LINK0 + i] = SLPD_PAT_FLICKER;
      else
        st_next.pat_sel[SLPD_LED_LINK0 + i] = SLPD_PAT_ON;
    end
    if (!live.module_pwr)
      st_next.pat_sel[SLPD_LED_PWR] = SLPD_PAT_OFF;
    else if (live.motor_comm)
      st_next.pat_sel[SLPD_LED_PWR] = SLPD_PAT_ON;
    else
      st_next.pat_sel[SLPD_LED_PWR] = SLPD_PAT_FLICKER;
    for (int i = 0; i < SLPD_GREEN_N; i++)
    begin
      if (st_reg.ovr_en[i])
        st_next.pat_sel[i] = st_reg.ovr_pat;
    end

    // The red LEDs are never patterned and cannot be overridden.
    st_next.sys_led = live.sys_fail;
    st_next.bus_led = live.bus_fail;

    // Events seen on the module state inputs.
    ev = '0;
    ev[SLPD_EV_SYS_FAIL] = live.sys_fail && !st_reg.prev.sys_fail;
    ev[SLPD_EV_BUS_FAIL] = live.bus_fail && !st_reg.prev.bus_fail;
    for (int i = 0; i < SLPD_PORTS; i++)
      ev[SLPD_EV_LINK0 + i] = live.link_up[i] != st_reg.prev.link_up[i];
    ev[SLPD_EV_COMM_LOSS] = live.module_pwr && st_reg.prev.motor_comm && !live.motor_comm;

    // Avalon slave with one wait state: the first cycle of a request
    // captures read data, the second drops waitrequest and commits.
    wr_go = I_AVS_WRITE && !st_reg.wait_req;
    clr = '0;
    if ((I_AVS_READ || I_AVS_WRITE) && st_reg.wait_req)
    begin
      st_next.wait_req = 1'b0;
      if (I_AVS_READ)
      begin
        case (addr)
          SLPD_REG_STATUS: st_next.rdata = 32'(stat);
          SLPD_REG_CTRL: st_next.rdata = 32'(st_reg.ovr_en);
          SLPD_REG_OVR_PAT: st_next.rdata = 32'(st_reg.ovr_pat);
          SLPD_REG_IRQ_STATUS: st_next.rdata = 32'(st_reg.irq_stat);
          SLPD_REG_IRQ_ENABLE: st_next.rdata = 32'(st_reg.irq_en);
          default: st_next.rdata = '0;
        endcase
      end
    end
    else
      st_next.wait_req = 1'b1;

    if (wr_go && I_AVS_BYTEENABLE[0])
    begin
      case (addr)
        SLPD_REG_CTRL: st_next.ovr_en = I_AVS_WRITEDATA[SLPD_GREEN_N-1:0];
        SLPD_REG_OVR_PAT: st_next.ovr_pat = slpd_pat_t'(I_AVS_WRITEDATA[2:0]);
        SLPD_REG_IRQ_CLEAR: clr = I_AVS_WRITEDATA[SLPD_IRQ_N-1:0];
        SLPD_REG_IRQ_ENABLE: st_next.irq_en = I_AVS_WRITEDATA[SLPD_IRQ_N-1:0];
        default: clr = '0;
      endcase
    end

    // An event in the clearing cycle survives the clear.
    st_next.irq_stat = (st_reg.irq_stat & ~clr) | ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      st_reg.ms_cnt <= '0;
      st_reg.ms_tick <= 1'b0;
      st_reg.prev <= '0;
      st_reg.act_cnt <= '0;
      st_reg.pat_sel <= {SLPD_GREEN_N{SLPD_PAT_OFF}};
      st_reg.sys_led <= 1'b0;
      st_reg.bus_led <= 1'b0;
      st_reg.ovr_en <= '0;
      st_reg.ovr_pat <= SLPD_PAT_OFF;
      st_reg.irq_stat <= '0;
      st_reg.irq_en <= '0;
      st_reg.irq <= 1'b0;
      st_reg.wait_req <= 1'b1;
      st_reg.rdata <= '0;
    end
    else
      st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Green LED pattern generators
  // ---------------------------------------------------------------
  for (genvar g = 0; g < SLPD_GREEN_N; g++)
  begin : gen_green
    slpd_pattern u_pat (
      .i_clk(I_CORE_CLK),
      .i_rst(I_RST),
      .i_ms_tick(st_reg.ms_tick),
      .i_pattern(st_reg.pat_sel[g]),
      .o_led(green[g])
    );
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign O_POWER_COMM_LED = green[SLPD_LED_PWR];
  assign O_LINK_ACT_LED = green[SLPD_LED_LINK0 +: SLPD_PORTS];
  assign O_SYSTEM_FAILURE_LED = st_reg.sys_led;
  assign O_BUS_FAILURE_LED = st_reg.bus_led;
  assign O_IRQ = st_reg.irq;
  assign O_AVS_READDATA = st_reg.rdata;
  assign O_AVS_WAITREQUEST = st_reg.wait_req;

endmodule

// ==== test/slpd_led_panel.sv ====
`timescale 1ns/100ps
module slpd_led_panel
  import slpd_pkg::*;
(
  input wire logic i_clk,
  input wire logic [4:0] i_leds
);
  // Lit runs are stored positive and dark runs negative, in clock cycles.
  int runs[$];
  int len = 0;
  logic prev;
  // Five lamps face the block; only the power lamp is timed.
  always @(posedge i_clk)
  begin
    if (i_leds[4] !== prev)
    begin
      runs.push_back(prev ? len : -len);
      len = 0;
    end
    prev = i_leds[4];
    len = len + 1;
  end
  function automatic void clear();
    runs.delete();
  endfunction
endmodule

// ==== test/slpd_checker.sv ====
`timescale 1ns/100ps
module slpd_checker
  import slpd_pkg::*;
#(
  parameter int MS_CYCLES = SLPD_MS_CYCLES
)
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [SLPD_ADDR_W-1:0] I_AVS_ADDRESS,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic O_AVS_WAITREQUEST,
  input wire logic [SLPD_PORTS-1:0] I_LINK_UP,
  input wire logic [SLPD_PORTS-1:0] I_LINE_ACT,
  input wire logic I_SYSTEM_FAIL,
  input wire logic I_BUS_FAIL,
  input wire logic I_MODULE_PWR,
  input wire logic I_MOTOR_COMM,
  input wire logic O_POWER_COMM_LED,
  input wire logic [SLPD_PORTS-1:0] O_LINK_ACT_LED,
  input wire logic O_SYSTEM_FAILURE_LED,
  input wire logic O_BUS_FAILURE_LED
);
  localparam int QT = 100 * MS_CYCLES + 8;
  localparam int FLK = 25 * MS_CYCLES + 12;
  localparam int HALF = 25 * MS_CYCLES;
  localparam int FLQ = 30 * MS_CYCLES;
  // Once software overrides the power LED its port rules no longer apply.
  logic ovr_reg;
  logic led_q;
  int run;
  int fl;
  int quiet;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  always_ff @(posedge I_CORE_CLK)
  begin
    led_q <= O_POWER_COMM_LED;
    run <= (O_POWER_COMM_LED != led_q) ? 1 : run + 1;
    if (I_RST)
    begin
      ovr_reg <= 1'b0;
      fl <= 0;
      quiet <= 0;
    end
    else
    begin
      fl <= (I_MODULE_PWR && !I_MOTOR_COMM) ? fl + 1 : 0;
      quiet <= (I_LINK_UP[1] && !I_LINE_ACT[1]) ? quiet + 1 : 0;
      if (I_AVS_WRITE && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == SLPD_REG_CTRL && I_AVS_WRITEDATA[0])
        ovr_reg <= 1'b1;
    end
  end
  sequence s_down0;
    !I_LINK_UP[0] [*3];
  endsequence
  sequence s_off;
    !I_MODULE_PWR [*3];
  endsequence
  sequence s_full;
    (I_MODULE_PWR && I_MOTOR_COMM) [*3];
  endsequence
  property p_sys_on;
    I_SYSTEM_FAIL |=> O_SYSTEM_FAILURE_LED;
  endproperty
  property p_bus_off;
    !I_BUS_FAIL |=> !O_BUS_FAILURE_LED;
  endproperty
  property p_link_off;
    s_down0 |=> !O_LINK_ACT_LED[0];
  endproperty
  property p_link_on;
    quiet > QT |-> O_LINK_ACT_LED[1];
  endproperty
  property p_link_flk;
    I_LINK_UP[0] && I_LINE_ACT[0] && O_LINK_ACT_LED[0] |-> ##[1:FLK] !O_LINK_ACT_LED[0];
  endproperty
  property p_pwr_off;
    disable iff (I_RST || ovr_reg) s_off |=> !O_POWER_COMM_LED;
  endproperty
  property p_pwr_on;
    disable iff (I_RST || ovr_reg) s_full |=> O_POWER_COMM_LED;
  endproperty
  property p_flick;
    disable iff (I_RST || ovr_reg) fl > FLQ && O_POWER_COMM_LED != led_q |-> run == HALF;
  endproperty
  a_sys_on: assert property (p_sys_on) else $error("system LED dark");
  a_bus_off: assert property (p_bus_off) else $error("bus LED lit");
  a_link_off: assert property (p_link_off) else $error("link LED lit");
  a_link_on: assert property (p_link_on) else $error("link LED not on");
  a_link_flk: assert property (p_link_flk) else $error("no flicker");
  a_pwr_off: assert property (p_pwr_off) else $error("power LED lit");
  a_pwr_on: assert property (p_pwr_on) else $error("power LED dark");
  a_flick: assert property (p_flick) else $error("flicker phase");
endmodule
bind slpd_top slpd_checker #(.MS_CYCLES(MS_CYCLES)) u_checker (
  .I_CORE_CLK, .I_RST, .I_AVS_ADDRESS, .I_AVS_WRITE, .I_AVS_WRITEDATA, .O_AVS_WAITREQUEST,
  .I_LINK_UP, .I_LINE_ACT, .I_SYSTEM_FAIL, .I_BUS_FAIL, .I_MODULE_PWR, .I_MOTOR_COMM,
  .O_POWER_COMM_LED, .O_LINK_ACT_LED, .O_SYSTEM_FAILURE_LED, .O_BUS_FAILURE_LED
);

// ==== test/status_led_pattern_driver_tb.sv ====
`timescale 1ns/100ps
module status_led_pattern_driver_tb
  import slpd_pkg::*;
;
  localparam int MS = 4;
  localparam int H = 200 * MS;
  localparam int F = 25 * MS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [SLPD_ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wreq;
  logic [1:0] lnk = 2'h2;
  logic [1:0] act = 2'h0;
  logic sf = 1'b0;
  logic bf = 1'b0;
  logic power_comm_led = 1'b0;
  logic com = 1'b0;
  logic pled;
  logic [1:0] lled;
  logic sled;
  logic bled;
  logic irq;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  slpd_top #(.MS_CYCLES(MS)) DUT (
    .I_CORE_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .I_LINK_UP(lnk), .I_LINE_ACT(act), .I_SYSTEM_FAIL(sf), .I_BUS_FAIL(bf), .I_MODULE_PWR(power_comm_led),
    .I_MOTOR_COMM(com), .O_POWER_COMM_LED(pled), .O_LINK_ACT_LED(lled), .O_SYSTEM_FAILURE_LED(sled),
    .O_BUS_FAILURE_LED(bled), .O_IRQ(irq)
  );
  slpd_led_panel PANEL (.i_clk(clk), .i_leds({pled, lled, sled, bled}));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [4:0] a[5] = '{SLPD_REG_CTRL, SLPD_REG_OVR_PAT, SLPD_REG_IRQ_CLEAR, SLPD_REG_IRQ_ENABLE, 5'h18};
    foreach (a[i]) rchk(a[i], 32'hffffffff, 32'h0);
    wreg(SLPD_REG_OVR_PAT, 32'h5);
    rchk(SLPD_REG_OVR_PAT, 32'h7, 32'h5);
    wreg(SLPD_REG_STATUS, 32'hffff);
    rchk(SLPD_REG_STATUS, 32'h1fff, 32'h402);
    $display("registers done");
  endtask
  task automatic t_red();
    int bad = 0;
    for (int k = 0; k < 4; k++)
    begin
      sf <= k[0];
      bf <= k[1];
      tick(2);
      cmp({sled, bled}, {k[0], k[1]});
    end
    repeat (900)
    begin
      @(posedge clk);
      bad += ({sled, bled} !== 2'h3);
    end
    cmp(bad, 0);
    rchk(SLPD_REG_STATUS, 32'h1830, 32'h1830);
    sf <= 1'b0;
    bf <= 1'b0;
    $display("red done");
  endtask
  task automatic t_irq();
    wreg(SLPD_REG_IRQ_CLEAR, 32'h1f);
    wreg(SLPD_REG_IRQ_ENABLE, 32'h1);
    tick(3);
    cmp(irq, 1'b0);
    sf <= 1'b1;
    tick(4);
    cmp(irq, 1'b1);
    rchk(SLPD_REG_IRQ_STATUS, 32'h1, 32'h1);
    wreg(SLPD_REG_IRQ_ENABLE, 32'h0);
    tick(3);
    cmp(irq, 1'b0);
    wreg(SLPD_REG_IRQ_CLEAR, 32'h1);
    rchk(SLPD_REG_IRQ_STATUS, 32'h1, 32'h0);
    wreg(SLPD_REG_IRQ_ENABLE, 32'h1);
    tick(3);
    cmp(irq, 1'b0);
    sf <= 1'b0;
    $display("irq done");
  endtask
  task automatic t_link();
    int dark = 0;
    act <= 2'h1;
    tick(20);
    cmp(lled[0], 1'b0);
    act <= 2'h0;
    tick(100 * MS + 20);
    lnk <= 2'h3;
    tick(4);
    cmp(lled[0], 1'b1);
    act <= 2'h1;
    tick(1);
    act <= 2'h0;
    repeat (100 * MS)
    begin
      @(posedge clk);
      dark += !lled[0];
    end
    cmp(dark >= 180 && dark <= 210, 1'b1);
    tick(60);
    cmp(lled[0], 1'b1);
    $display("link done");
  endtask
  task automatic t_power();
    cmp(pled, 1'b0);
    power_comm_led <= 1'b1;
    com <= 1'b1;
    tick(5);
    cmp(pled, 1'b1);
    PANEL.clear();
    com <= 1'b0;
    tick(5 * F);
    cmp(PANEL.runs[1], -F);
    cmp(PANEL.runs[2], F);
    com <= 1'b1;
    $display("power done");
  endtask
  task automatic t_pattern();
    slpd_pat_t p[5] = '{SLPD_PAT_BLINK, SLPD_PAT_SINGLE, SLPD_PAT_DOUBLE, SLPD_PAT_TRIPLE, SLPD_PAT_FLICKER};
    int e[$];
    int sum;
    int d = 1000 * MS;
    wreg(SLPD_REG_CTRL, 32'h1);
    rchk(SLPD_REG_CTRL, 32'h7, 32'h1);
    for (int i = 0; i < 5; i++)
    begin
      case (i)
        0: e = '{H, -H};
        1: e = '{H, -d};
        2: e = '{H, -H, H, -d};
        3: e = '{H, -H, H, -H, H, -d};
        default: e = '{F, -F};
      endcase
      wreg(SLPD_REG_OVR_PAT, 32'h0);
      tick(10);
      PANEL.clear();
      wreg(SLPD_REG_OVR_PAT, 32'(p[i]));
      sum = 0;
      foreach (e[k]) sum += (e[k] > 0) ? e[k] : -e[k];
      tick(2 * sum);
      cmp(PANEL.runs[1] >= e[0] - 4 && PANEL.runs[1] <= e[0] + 4, 1'b1);
      foreach (e[k]) cmp(PANEL.runs[k + 2], e[(k + 1) % e.size()]);
    end
    $display("patterns done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    forever #50 clk = ~clk;
  end
  // The ceiling covers the longest flash patterns with room to spare.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_red();
    t_irq();
    t_link();
    t_power();
    t_pattern();
    summarize();
  end
endmodule
